// File: logic/ief_pkg.sv
// constants, encodings and register map of the intermittent earth fault stage
package ief_pkg;
	localparam int          CLK_HZ         = 50_000_000;
	localparam int          TICK_MS        = 5;
	localparam int          TICK_CYC       = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] FWD_HOLD_RST   = 16'h003C;
	localparam logic [15:0] REV_HOLD_RST   = 16'h003C;
	localparam logic [15:0] OPER_DELAY_RST = 16'h0064;
	localparam logic [7:0]  SPIKE_TRIP_RST = 8'h02;
	localparam logic [15:0] VTHR_RST       = 16'h1F40;
	localparam logic [15:0] ITHR_RST       = 16'h0032;
	localparam logic [1:0]  CHAN_A         = 2'h1;
	localparam logic [1:0]  CHAN_B         = 2'h2;
	localparam logic [7:0]  A_CTRL         = 8'h00;
	localparam logic [7:0]  A_VTHR         = 8'h04;
	localparam logic [7:0]  A_ITHR         = 8'h08;
	localparam logic [7:0]  A_FWDHOLD      = 8'h0C;
	localparam logic [7:0]  A_REVHOLD      = 8'h10;
	localparam logic [7:0]  A_OPDELAY      = 8'h14;
	localparam logic [7:0]  A_SPIKES       = 8'h18;
	localparam logic [7:0]  A_STATUS       = 8'h1C;
	localparam logic [7:0]  A_REMAIN       = 8'h20;
	localparam logic [7:0]  A_SPKLEFT      = 8'h24;
	localparam logic [7:0]  A_EXPECT       = 8'h28;
	localparam logic [7:0]  A_COUNTS       = 8'h2C;
	localparam int          CTRL_CHAN      = 0;
	localparam int          CTRL_FORCE     = 4;
	localparam int          CTRL_FEN       = 8;
	localparam int          CTRL_VCHAN     = 12;
	typedef enum logic [2:0] {
		FORCE_NORMAL = 3'h0,
		FORCE_BLOCK  = 3'h1,
		FORCE_FWD    = 3'h2,
		FORCE_REV    = 3'h3,
		FORCE_TRIP   = 3'h4
	} force_t;
	typedef enum logic [2:0] {
		COND_NORMAL = 3'h0,
		COND_FWD    = 3'h1,
		COND_REV    = 3'h2,
		COND_TRIP   = 3'h3,
		COND_BLOCK  = 3'h4
	} cond_t;
endpackage : ief_pkg

// File: logic/intermittent_fault_stage.sv
// intermittent earth fault stage: spike detection, hold timers, trip logic
// Summary of operation
// - residual current taken from input a (code 1, default) or b (code 2)
// - voltage and current kept in circular sample buffers, evaluated every 5 ms
// - force setting overrides outputs while global and local forcing enabled
// - buffer maxima compared continuously with voltage and current spike thresholds
// - start only when unblocked and both thresholds exceeded
// - blocking input sampled at start of each program cycle
// - unblocked pick-up asserts start and runs operating timers
// - blocked pick-up asserts blocked, no further processing
// - blocking during start drops start like pick-up release
// - blocked output activation (blocked pick-up) raises a display event and a blocking event
// - forward hold timer restarts on forward spikes, drops forward start on expiry
// - reverse hold timer restarts on reverse spikes, drops reverse start on expiry
// - operating timer runs while forward hold runs and start on
// - trip needs forward spikes above trip_spike_count, else release on hold expiry
// - definite time trip after set delay while pick-up active
// - condition indicator: 0 normal, 1 forward, 2 reverse, 3 trip, 4 blocked
// - voltage channel indicator: 0 none, 1 first, 2 second
// - time remaining to trip reported in 5 ms steps
// - 32-bit count of spikes still needed before trip
// - expected operating time reported in 5 ms steps
// - admittance delta is current difference over voltage difference
// - negative admittance delta is a forward spike
// - on/off events for forward, reverse, trip and blocked; detection changes come with a start change and are never reported
module intermittent_fault_stage
	import ief_pkg::*;
#(
	parameter int SW    = 16,
	parameter int DEPTH = 8,
	parameter int TICKS = TICK_CYC
) (
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire logic          sampleValid,
	input  wire logic [SW-1:0] residualVoltage,
	input  wire logic [SW-1:0] residual_current_input_a,
	input  wire logic [SW-1:0] residual_current_input_b,
	input  wire logic          blockIn,
	input  wire logic          stageForceEnable,
	input  wire logic [7:0]    regAddr,
	input  wire logic [31:0]   regWdata,
	input  wire logic          regWrite,
	input  wire logic          regRead,
	output logic      [31:0]   regRdata,
	output logic               forward_start,
	output logic               reverse_start,
	output logic               tripOut,
	output logic               blockedOut,
	output logic               faultDetected,
	output logic               eventOn,
	output logic               eventOff,
	output logic      [2:0]    eventSource,
	output logic               blockEvent,
	output logic               displayEvent
);
	// synchronised asynchronous pins
	logic [1:0] blkSync, fenSync;
	always_ff @(posedge ref_clk) begin
		blkSync <= {blkSync[0], blockIn};
		fenSync <= {fenSync[0], stageForceEnable};
	end

	// settings
	logic [1:0]  chanSel;
	logic [1:0]  voltChan;
	force_t      forceSel;
	logic        forceLocal;
	logic [15:0] voltage_spike_threshold, current_spike_threshold;
	logic [15:0] forward_hold_time, reverse_hold_time, definite_time_delay;
	logic [7:0]  trip_spike_count;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			chanSel                 <= CHAN_A;
			voltChan                <= 2'h1;
			forceSel                <= FORCE_NORMAL;
			forceLocal              <= 1'b0;
			voltage_spike_threshold <= VTHR_RST;
			current_spike_threshold <= ITHR_RST;
			forward_hold_time       <= FWD_HOLD_RST;
			reverse_hold_time       <= REV_HOLD_RST;
			definite_time_delay     <= OPER_DELAY_RST;
			trip_spike_count        <= SPIKE_TRIP_RST;
		end else if (regWrite) begin
			unique case (regAddr)
				A_CTRL: begin
					if (regWdata[CTRL_CHAN+:2] == CHAN_A || regWdata[CTRL_CHAN+:2] == CHAN_B)
						chanSel <= regWdata[CTRL_CHAN+:2];
					if (regWdata[CTRL_FORCE+:3] <= 3'h4)
						forceSel <= force_t'(regWdata[CTRL_FORCE+:3]);
					forceLocal <= regWdata[CTRL_FEN];
					if (regWdata[CTRL_VCHAN+:2] != 2'h3)
						voltChan <= regWdata[CTRL_VCHAN+:2];
				end
				A_VTHR:    voltage_spike_threshold <= regWdata[15:0];
				A_ITHR:    current_spike_threshold <= regWdata[15:0];
				A_FWDHOLD: forward_hold_time <= regWdata[15:0];
				A_REVHOLD: reverse_hold_time <= regWdata[15:0];
				A_OPDELAY: definite_time_delay <= regWdata[15:0];
				A_SPIKES:  trip_spike_count <= regWdata[7:0];
				default: ;
			endcase
		end
	end

	// program cycle tick, 5 ms
	logic [$clog2(TICKS)-1:0] tickCnt;
	logic                     tick;
	assign tick = (tickCnt == '0);
	always_ff @(posedge ref_clk) begin
		if (rst || tick)
			tickCnt <= $clog2(TICKS)'(TICKS - 1);
		else
			tickCnt <= tickCnt - 1'b1;
	end

	// circular sample buffers
	logic [SW-1:0] uBuf [DEPTH];
	logic [SW-1:0] iBuf [DEPTH];
	logic [$clog2(DEPTH)-1:0] wrPtr;
	logic [SW-1:0] curSample;
	assign curSample = (chanSel == CHAN_B) ? residual_current_input_b
	                                       : residual_current_input_a;
	always_ff @(posedge ref_clk) begin
		if (rst)
			wrPtr <= '0;
		else if (sampleValid) begin
			uBuf[wrPtr] <= residualVoltage;
			iBuf[wrPtr] <= curSample;
			wrPtr       <= wrPtr + 1'b1;
		end
	end

	// buffer maxima and signed deltas between newest and previous sample
	logic [SW-1:0] uMax, iMax;
	always_comb begin
		uMax = '0;
		iMax = '0;
		for (int k = 0; k < DEPTH; k++) begin
			if (uBuf[k] > uMax) uMax = uBuf[k];
			if (iBuf[k] > iMax) iMax = iBuf[k];
		end
	end
	logic [$clog2(DEPTH)-1:0] newPtr, oldPtr;
	assign newPtr = wrPtr - 1'b1;
	assign oldPtr = wrPtr - 2'h2;
	logic signed [SW:0] dU, dI;
	assign dU = $signed({1'b0, uBuf[newPtr]}) - $signed({1'b0, uBuf[oldPtr]});
	assign dI = $signed({1'b0, iBuf[newPtr]}) - $signed({1'b0, iBuf[oldPtr]});
	logic pickUp, fwdSpike, revSpike;
	// sign of dI/dU without a divider: negative when signs differ
	assign pickUp   = (uMax > voltage_spike_threshold) &&
	                  (iMax > current_spike_threshold) && (dU != '0);
	assign fwdSpike = tick && pickUp && (dI[SW] ^ dU[SW]) && (dI != '0);
	assign revSpike = tick && pickUp && !(dI[SW] ^ dU[SW]) && (dI != '0);

	// block check once per program cycle
	logic blocked;
	always_ff @(posedge ref_clk) begin
		if (rst)
			blocked <= 1'b0;
		else if (tick)
			blocked <= blkSync[1];
	end

	// hold timers, operating timer, spike counters
	logic [15:0] fwdHold, revHold, operCnt;
	logic        fwdRun, revRun, tripped, blkState;
	logic [31:0] fwdSpikes, revSpikes;
	always_ff @(posedge ref_clk) begin
		if (rst || blocked) begin
			fwdRun  <= 1'b0;
			revRun  <= 1'b0;
			fwdHold <= '0;
			revHold <= '0;
			operCnt <= '0;
			tripped <= 1'b0;
			fwdSpikes <= '0;
			revSpikes <= '0;
		end else if (tick) begin
			if (fwdSpike) begin
				fwdRun    <= 1'b1;
				fwdHold   <= forward_hold_time;
				fwdSpikes <= fwdSpikes + 1'b1;
			end else if (fwdRun && fwdHold <= 16'h0001) begin
				fwdRun    <= 1'b0;
				operCnt   <= '0;
				tripped   <= 1'b0;
				fwdSpikes <= '0;
			end else if (fwdRun)
				fwdHold <= fwdHold - 1'b1;
			if (revSpike) begin
				revRun    <= 1'b1;
				revHold   <= reverse_hold_time;
				revSpikes <= revSpikes + 1'b1;
			end else if (revRun && revHold <= 16'h0001) begin
				revRun    <= 1'b0;
				revSpikes <= '0;
			end else if (revRun)
				revHold <= revHold - 1'b1;
			if ((fwdRun || fwdSpike) && !tripped && operCnt < definite_time_delay)
				operCnt <= operCnt + 1'b1;
			if (fwdRun && operCnt >= definite_time_delay &&
			    fwdSpikes > 32'(trip_spike_count))
				tripped <= 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst)
			blkState <= 1'b0;
		else
			blkState <= blocked && (pickUp || blkState);
	end

	// forced or live outputs
	logic forcing;
	logic next_fwd, next_rev, next_trip, next_blk;
	assign forcing = fenSync[1] && forceLocal;
	always_comb begin
		next_fwd  = fwdRun;
		next_rev  = revRun;
		next_trip = tripped;
		next_blk  = blkState;
		if (forcing) begin
			next_fwd  = (forceSel == FORCE_FWD);
			next_rev  = (forceSel == FORCE_REV);
			next_trip = (forceSel == FORCE_TRIP);
			next_blk  = (forceSel == FORCE_BLOCK);
		end
	end
	logic [4:0] prevOut, curOut;
	assign curOut = {next_blk, next_trip, next_rev, next_fwd, next_fwd | next_rev};
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			forward_start <= 1'b0;
			reverse_start <= 1'b0;
			tripOut       <= 1'b0;
			blockedOut    <= 1'b0;
			faultDetected <= 1'b0;
			prevOut       <= '0;
		end else begin
			forward_start <= next_fwd;
			reverse_start <= next_rev;
			tripOut       <= next_trip;
			blockedOut    <= next_blk;
			faultDetected <= curOut[0];
			prevOut       <= curOut;
		end
	end

	// events: one per cycle, the highest changed output index is reported
	logic [4:0] chg;
	assign chg = curOut ^ prevOut;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			eventOn      <= 1'b0;
			eventOff     <= 1'b0;
			eventSource  <= 3'h0;
			blockEvent   <= 1'b0;
			displayEvent <= 1'b0;
		end else begin
			eventOn      <= 1'b0;
			eventOff     <= 1'b0;
			eventSource  <= 3'h0;
			for (int k = 0; k <= 4; k++) begin
				if (chg[k]) begin
					eventOn     <= curOut[k];
					eventOff    <= !curOut[k];
					eventSource <= 3'(k);
				end
			end
			blockEvent   <= chg[4] && curOut[4];
			displayEvent <= chg[4] && curOut[4];
		end
	end

	// read-only values
	cond_t       cond;
	logic [15:0] remain;
	logic [31:0] spkLeft;
	always_comb begin
		if (next_blk)       cond = COND_BLOCK;
		else if (next_trip) cond = COND_TRIP;
		else if (next_fwd)  cond = COND_FWD;
		else if (next_rev)  cond = COND_REV;
		else                cond = COND_NORMAL;
	end
	assign remain  = (fwdRun && operCnt < definite_time_delay) ?
	                 definite_time_delay - operCnt : '0;
	assign spkLeft = (fwdSpikes > 32'(trip_spike_count)) ? '0 :
	                 32'(trip_spike_count) + 32'h1 - fwdSpikes;
	always_ff @(posedge ref_clk) begin
		if (rst)
			regRdata <= '0;
		else if (regRead) begin
			unique case (regAddr)
				A_CTRL:    regRdata <= {18'h0, voltChan, 3'h0, forceLocal, 1'b0,
				                        forceSel, 2'h0, chanSel};
				A_VTHR:    regRdata <= {16'h0, voltage_spike_threshold};
				A_ITHR:    regRdata <= {16'h0, current_spike_threshold};
				A_FWDHOLD: regRdata <= {16'h0, forward_hold_time};
				A_REVHOLD: regRdata <= {16'h0, reverse_hold_time};
				A_OPDELAY: regRdata <= {16'h0, definite_time_delay};
				A_SPIKES:  regRdata <= {24'h0, trip_spike_count};
				A_STATUS:  regRdata <= {26'h0, voltChan, 1'b0, cond};
				A_REMAIN:  regRdata <= {16'h0, remain};
				A_SPKLEFT: regRdata <= spkLeft;
				A_EXPECT:  regRdata <= {16'h0, definite_time_delay};
				A_COUNTS:  regRdata <= {fwdSpikes[15:0], revSpikes[15:0]};
				default:   regRdata <= '0;
			endcase
		end else
			regRdata <= '0;
	end

	a_fwd_expiry: assert property (@(posedge ref_clk) disable iff (rst)
		tick && !blocked && fwdRun && !fwdSpike && fwdHold <= 16'h0001 |=> !fwdRun)
		else $error("forward hold did not expire");
	a_rev_expiry: assert property (@(posedge ref_clk) disable iff (rst)
		tick && !blocked && revRun && !revSpike && revHold <= 16'h0001 |=> !revRun)
		else $error("reverse hold did not expire");
	a_block_drop: assert property (@(posedge ref_clk) disable iff (rst)
		blocked |=> !fwdRun && !revRun)
		else $error("start survived blocking");
	a_trip_count: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(tripped) |-> $past(fwdSpikes) > 32'($past(trip_spike_count)))
		else $error("trip without enough spikes");
	a_block_sample: assert property (@(posedge ref_clk) disable iff (rst)
		!tick |=> $stable(blocked))
		else $error("block sampled outside tick");
	a_force_trip: assert property (@(posedge ref_clk) disable iff (rst)
		forcing && forceSel == FORCE_TRIP |=> tripOut && !forward_start)
		else $error("forced trip not applied");
	a_cond_trip: assert property (@(posedge ref_clk) disable iff (rst)
		next_trip && !next_blk |-> cond == COND_TRIP)
		else $error("condition code wrong");
	a_block_event: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(blockedOut) |-> blockEvent && displayEvent)
		else $error("blocking event missing");
	c_fwd_start:  cover property (@(posedge ref_clk) $rose(forward_start));
	c_trip:       cover property (@(posedge ref_clk) $rose(tripOut));
	c_blocked:    cover property (@(posedge ref_clk) $rose(blockedOut));
endmodule : intermittent_fault_stage

// File: sim/front_end_model.sv
// residual voltage and current front end model feeding the sample buffers
module front_end_model (
	input  wire logic        ref_clk,
	output logic             sampleValid,
	output logic [15:0]      residualVoltage,
	output logic [15:0]      currentA,
	output logic [15:0]      currentB
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		sampleValid = 1'b0;
		residualVoltage = 16'h0000;
		currentA = 16'h0000;
		currentB = 16'h0000;
	end

	// one-cycle sample pulse; afterwards the lines carry the inverse so stale data never matches
	task automatic send(input logic [15:0] v, input logic [15:0] a, input logic [15:0] b);
		@(posedge ref_clk);
		sampleValid <= 1'b1;
		residualVoltage <= v;
		currentA <= a;
		currentB <= b;
		@(posedge ref_clk);
		sampleValid <= 1'b0;
		residualVoltage <= ~v;
		currentA <= ~a;
		currentB <= ~b;
	endtask : send
endmodule : front_end_model

// File: sim/intermittent_fault_stage_test.sv
// self-checking bench of the intermittent earth fault stage
module intermittent_fault_stage_test;
	import ief_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 10;
	logic        ref_clk, rst, sampleValid, blockIn, stageForceEnable, regWrite, regRead;
	logic [15:0] residualVoltage, currentA, currentB, vLvl, iLvl;
	logic [7:0]  regAddr;
	logic [31:0] regWdata, regRdata, rdv;
	logic        forward_start, reverse_start, tripOut, blockedOut, eventOn;
	logic        blockEvent, displayEvent, sawBlkEv;
	logic [2:0]  eventSource, lastOn;
	logic [3:0]  outs;
	int          failures, cmpCount;

	assign outs = {blockedOut, tripOut, reverse_start, forward_start};

	front_end_model i_front_end_model (.ref_clk(ref_clk), .sampleValid(sampleValid),
		.residualVoltage(residualVoltage), .currentA(currentA), .currentB(currentB));

	intermittent_fault_stage #(.SW(16), .DEPTH(8), .TICKS(TK)) i_intermittent_fault_stage (
		.ref_clk(ref_clk), .rst(rst), .sampleValid(sampleValid),
		.residualVoltage(residualVoltage), .residual_current_input_a(currentA),
		.residual_current_input_b(currentB), .blockIn(blockIn),
		.stageForceEnable(stageForceEnable), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.forward_start(forward_start), .reverse_start(reverse_start), .tripOut(tripOut),
		.blockedOut(blockedOut), .faultDetected(), .eventOn(eventOn), .eventOff(),
		.eventSource(eventSource), .blockEvent(blockEvent), .displayEvent(displayEvent));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (eventOn === 1'b1) lastOn <= eventSource;
	end

	always @(posedge ref_clk) begin
		if (blockEvent === 1'b1 && displayEvent === 1'b1) sawBlkEv <= 1'b1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask : rd

	task automatic waitOut(input int idx, input logic want, input int lim);
		int n;
		n = 0;
		while (outs[idx] !== want && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		check({31'h0, outs[idx]}, {31'h0, want});
	endtask : waitOut

	// one step sample then a flat one, spaced so exactly one tick sees the step
	task automatic spike(input logic forward_direction, input logic useB);
		vLvl = vLvl + 16'h0010;
		iLvl = forward_direction ? iLvl - 16'h0010 : iLvl + 16'h0010;
		repeat (2) begin
			i_front_end_model.send(vLvl, useB ? 16'h0400 : iLvl, useB ? iLvl : 16'h0400);
			repeat (TK - 2) @(posedge ref_clk);
		end
	endtask : spike

	task automatic defaults_and_setup;
		logic [7:0]  ad [9];
		logic [31:0] ex [9];
		ad = '{A_CTRL, A_VTHR, A_ITHR, A_FWDHOLD, A_REVHOLD, A_OPDELAY, A_SPIKES, A_STATUS, 8'h40};
		ex = '{32'h1001, {16'h0, VTHR_RST}, {16'h0, ITHR_RST}, {16'h0, FWD_HOLD_RST},
			{16'h0, REV_HOLD_RST}, {16'h0, OPER_DELAY_RST}, {24'h0, SPIKE_TRIP_RST}, 32'h10, 32'h0};
		for (int k = 0; k < 9; k++) begin
			rd(ad[k], rdv);
			check(rdv, ex[k]);
		end
		wr(A_CTRL, 32'h0001);
		rd(A_STATUS, rdv);
		check(rdv & 32'h30, 32'h0);
		wr(A_CTRL, 32'h2001);
		rd(A_STATUS, rdv);
		check(rdv & 32'h30, 32'h20);
		wr(A_CTRL, 32'h1001);
		wr(A_VTHR, 32'h0100);
		wr(A_ITHR, 32'h0100);
		wr(A_FWDHOLD, 32'd20);
		wr(A_REVHOLD, 32'd6);
		wr(A_OPDELAY, 32'd4);
		rd(A_EXPECT, rdv);
		check(rdv, 32'd4);
		// priming from empty buffers may count as a reverse spike; let it expire
		spike(1'b0, 1'b0);
		waitOut(1, 1'b0, 12 * TK);
	endtask : defaults_and_setup

	task automatic forcing;
		logic [3:0] ex [5];
		ex = '{4'h0, 4'h8, 4'h1, 4'h2, 4'h4};
		stageForceEnable <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			wr(A_CTRL, 32'h1101 | (c << 4));
			repeat (5) @(posedge ref_clk);
			check({28'h0, outs}, {28'h0, ex[c]});
		end
		stageForceEnable <= 1'b0;
		repeat (5) @(posedge ref_clk);
		check({28'h0, outs}, 32'h0);
		wr(A_CTRL, 32'h1001);
	endtask : forcing

	task automatic forward_trip;
		spike(1'b1, 1'b0);
		check({31'h0, forward_start}, 32'h1);
		check({29'h0, lastOn}, 32'h1);
		rd(A_SPKLEFT, rdv);
		check(rdv, 32'h2);
		spike(1'b1, 1'b0);
		repeat (3 * TK) @(posedge ref_clk);
		check({30'h0, tripOut, reverse_start}, 32'h0);
		spike(1'b1, 1'b0);
		waitOut(2, 1'b1, 3 * TK);
		@(posedge ref_clk);
		check({29'h0, lastOn}, 32'h3);
		waitOut(0, 1'b0, 25 * TK);
	endtask : forward_trip

	task automatic reverse_on_b;
		wr(A_CTRL, 32'h1002);
		spike(1'b0, 1'b1);
		check({30'h0, forward_start, reverse_start}, 32'h1);
		waitOut(1, 1'b0, 10 * TK);
	endtask : reverse_on_b

	task automatic blocking;
		spike(1'b1, 1'b1);
		check({31'h0, forward_start}, 32'h1);
		// the source raises the block one program cycle before the operating delay would run out
		blockIn <= 1'b1;
		sawBlkEv <= 1'b0;
		repeat (2 * TK) @(posedge ref_clk);
		// a fresh pick-up while blocked raises the blocked output
		spike(1'b1, 1'b1);
		waitOut(3, 1'b1, 4 * TK);
		@(posedge ref_clk);
		check({31'h0, sawBlkEv}, 32'h1);
		repeat (2) @(posedge ref_clk);
		check({30'h0, forward_start, tripOut}, 32'h0);
		rd(A_STATUS, rdv);
		check(rdv & 32'h7, {29'h0, COND_BLOCK});
		blockIn <= 1'b0;
	endtask : blocking

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		report_and_stop;
	end

	initial begin
		failures = 0;
		cmpCount = 0;
		rst = 1'b1;
		blockIn = 1'b0;
		stageForceEnable = 1'b0;
		regAddr = 8'h00;
		regWdata = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		lastOn = 3'h0;
		sawBlkEv = 1'b0;
		vLvl = 16'h0200;
		iLvl = 16'h0400;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		defaults_and_setup;
		forcing;
		forward_trip;
		reverse_on_b;
		blocking;
		report_and_stop;
	end
endmodule : intermittent_fault_stage_test
